// *** common/twe_pkg.sv ***
// constants and types shared by the two-wire memory slave
package twe_pkg;

  // system clock rate and the self-timed programming window
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned PROG_TIME_MS = 5;
  localparam int unsigned PROG_CYCLES = PROG_TIME_MS * (CLK_HZ / 1000);

  // device type identifier: value is arbitrary
  localparam logic [3:0] TYPE_ID = 4'h5;

  // slave address byte layout
  localparam int unsigned DIR_BIT = 0;
  localparam int unsigned STRAP_LSB = 1;
  localparam int unsigned STRAP_MSB = 3;
  localparam int unsigned ID_LSB = 4;
  localparam int unsigned ID_MSB = 7;

  // memory organisation
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned MEM_DEPTH = 128;
  localparam int unsigned PAGE_W = 2;
  localparam int unsigned PAGE_BYTES = 4;
  localparam int unsigned BASE_W = ADDR_W - PAGE_W;
  localparam int unsigned STRAP_W = 3;

  // address reset value and last bit count
  localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // pins captured by the synchroniser
  typedef struct packed {
    logic scl;
    logic sda;
    logic wi;
    logic [STRAP_W-1:0] straps;
  } twe_pins_type;

  typedef enum {
    TWE_IDLE,
    TWE_DEVADDR,
    TWE_DEVACK,
    TWE_WORDADDR,
    TWE_WORDACK,
    TWE_WDATA,
    TWE_WDATAACK,
    TWE_RDATA,
    TWE_RACK,
    TWE_WAITSTOP
  } twe_state_type;

endpackage

// *** core/twe_eeprom_slave.sv ***
// two-wire serial slave front end of a 128-byte nonvolatile memory
`timescale 1ns/1ps
`default_nettype none

module twe_eeprom_slave
  import twe_pkg::*;
#(
  parameter int unsigned PROG_CYCLES_P = PROG_CYCLES
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [STRAP_W-1:0] slave_select_straps,
  input wire logic write_inhibit_input,
  output logic sda_out,
  output logic sda_oe,
  output logic prog_busy
);

  localparam int unsigned CNT_W = $clog2(PROG_CYCLES_P + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PROG_CYCLES_P - 1);

  twe_pins_type pins_raw;
  twe_pins_type sync1_q;
  twe_pins_type sync2_q;
  twe_pins_type prev_q;
  twe_state_type state_q;
  logic [BYTE_W-1:0] mem [MEM_DEPTH];
  logic [BYTE_W-1:0] page_buf_q [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_valid_q;
  logic [BASE_W-1:0] page_base_q;
  logic [BYTE_W-1:0] shift_q;
  logic [BYTE_W-1:0] tx_q;
  logic [BYTE_W-1:0] rx_byte;
  logic [BYTE_W-1:0] mem_rd;
  logic [ADDR_W-1:0] addr_q;
  logic [2:0] bit_cnt_q;
  logic [CNT_W-1:0] prog_cnt_q;
  logic busy_q;
  logic read_q;
  logic ack_phase_q;
  logic master_ack_q;
  logic sda_oe_q;
  logic sda_out_q;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic byte_done;
  logic addr_match;
  logic in_ack;
  logic ack_leave;
  logic load_tx;
  logic prog_done;
  logic prog_start;

  assign pins_raw = {scl_in, sda_in, write_inhibit_input,
                     slave_select_straps};

  // two-stage synchroniser; only the second stage feeds logic
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sync1_q <= '1;
      sync2_q <= '1;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  // previous sample for edge detection
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prev_q <= '1;
    end else begin
      prev_q <= sync2_q;
    end
  end

  assign scl_rise = sync2_q.scl & ~prev_q.scl;
  assign scl_fall = ~sync2_q.scl & prev_q.scl;
  assign start_ev = sync2_q.scl & prev_q.scl & prev_q.sda &
                    ~sync2_q.sda;
  assign stop_ev = sync2_q.scl & prev_q.scl & ~prev_q.sda & sync2_q.sda;

  assign rx_byte = {shift_q[BYTE_W-2:0], sync2_q.sda};
  assign byte_done = scl_rise & (bit_cnt_q == BIT_LAST);
  assign addr_match = (rx_byte[ID_MSB:ID_LSB] == TYPE_ID) &&
                      (rx_byte[STRAP_MSB:STRAP_LSB] == sync2_q.straps);
  assign in_ack = (state_q == TWE_DEVACK) || (state_q == TWE_WORDACK) ||
                  (state_q == TWE_WDATAACK);
  assign ack_leave = in_ack & scl_fall & ack_phase_q;
  assign load_tx = ((state_q == TWE_DEVACK) & ack_leave & read_q) ||
                   ((state_q == TWE_RACK) & scl_fall & master_ack_q);
  assign mem_rd = mem[addr_q];
  assign prog_done = busy_q & (prog_cnt_q == CNT_LAST);
  assign prog_start = ~busy_q & stop_ev & (|page_valid_q) &
                      ((state_q == TWE_WDATA) || (state_q == TWE_WDATAACK)) &
                      ~sync2_q.wi;

  // bus sequencer
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= TWE_IDLE;
      read_q <= 1'b0;
    end else if (busy_q) begin
      state_q <= TWE_IDLE;
    end else if (stop_ev) begin
      state_q <= TWE_IDLE;
    end else if (start_ev) begin
      state_q <= TWE_DEVADDR;
    end else begin
      unique case (state_q)
        TWE_IDLE: begin
          state_q <= TWE_IDLE;
        end
        TWE_DEVADDR: begin
          if (byte_done) begin
            if (addr_match) begin
              state_q <= TWE_DEVACK;
              read_q <= rx_byte[DIR_BIT];
            end else begin
              state_q <= TWE_IDLE;
            end
          end
        end
        TWE_DEVACK: begin
          if (ack_leave) begin
            state_q <= read_q ? TWE_RDATA : TWE_WORDADDR;
          end
        end
        TWE_WORDADDR: begin
          if (byte_done) begin
            state_q <= TWE_WORDACK;
          end
        end
        TWE_WORDACK: begin
          if (ack_leave) begin
            state_q <= TWE_WDATA;
          end
        end
        TWE_WDATA: begin
          if (byte_done) begin
            state_q <= TWE_WDATAACK;
          end
        end
        TWE_WDATAACK: begin
          if (ack_leave) begin
            state_q <= TWE_WDATA;
          end
        end
        TWE_RDATA: begin
          if (scl_fall && (bit_cnt_q == 3'h0)) begin
            state_q <= TWE_RACK;
          end
        end
        TWE_RACK: begin
          if (scl_fall) begin
            state_q <= master_ack_q ? TWE_RDATA : TWE_WAITSTOP;
          end
        end
        TWE_WAITSTOP: begin
          state_q <= TWE_WAITSTOP;
        end
      endcase
    end
  end

  // bit counter and receive shifter, sampled on clock rise
  always_ff @(posedge sys_clk) begin
    if (srst || busy_q || start_ev || stop_ev) begin
      bit_cnt_q <= 3'h0;
      shift_q <= 8'h00;
    end else if (scl_rise) begin
      if ((state_q == TWE_DEVADDR) || (state_q == TWE_WORDADDR) ||
          (state_q == TWE_WDATA) || (state_q == TWE_RDATA)) begin
        shift_q <= rx_byte;
        bit_cnt_q <= bit_cnt_q + 3'h1;
      end
    end
  end

  // ninth-clock phase: first fall drives, second fall releases or, after a read address, sends the first data bit
  always_ff @(posedge sys_clk) begin
    if (srst || busy_q || start_ev || stop_ev) begin
      ack_phase_q <= 1'b0;
    end else if (in_ack && scl_fall) begin
      ack_phase_q <= ~ack_phase_q;
    end
  end

  // master acknowledge after a read byte
  always_ff @(posedge sys_clk) begin
    if (srst || start_ev || stop_ev) begin
      master_ack_q <= 1'b0;
    end else if ((state_q == TWE_RACK) && scl_rise) begin
      master_ack_q <= ~sync2_q.sda;
    end
  end

  // open-drain data drive, changed on clock fall and cleared on start, stop or busy
  always_ff @(posedge sys_clk) begin
    if (srst || busy_q || start_ev || stop_ev) begin
      sda_oe_q <= 1'b0;
    end else if (scl_fall) begin
      if (in_ack) begin
        if (!ack_phase_q) begin
          sda_oe_q <= 1'b1;
        end else if ((state_q == TWE_DEVACK) && read_q) begin
          sda_oe_q <= ~mem_rd[BYTE_W-1];
        end else begin
          sda_oe_q <= 1'b0;
        end
      end else if (state_q == TWE_RDATA) begin
        if (bit_cnt_q == 3'h0) begin
          sda_oe_q <= 1'b0;
        end else begin
          sda_oe_q <= ~tx_q[BIT_LAST - bit_cnt_q];
        end
      end else if (state_q == TWE_RACK) begin
        sda_oe_q <= master_ack_q & ~mem_rd[BYTE_W-1];
      end else begin
        sda_oe_q <= 1'b0;
      end
    end
  end

  // the pin is only ever pulled low; the clock pin is never driven
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sda_out_q <= 1'b0;
    end else begin
      sda_out_q <= 1'b0;
    end
  end

  // transmit byte latched as its first bit goes out
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_q <= 8'h00;
    end else if (load_tx) begin
      tx_q <= mem_rd;
    end
  end

  // address counter
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      addr_q <= ADDR_RST;
    end else if (!busy_q) begin
      if (load_tx) begin
        addr_q <= addr_q + 7'h01;
      end else if ((state_q == TWE_WORDADDR) && byte_done && !start_ev) begin
        addr_q <= rx_byte[ADDR_W-1:0];
      end else if ((state_q == TWE_WDATA) && byte_done && !start_ev) begin
        addr_q[PAGE_W-1:0] <= addr_q[PAGE_W-1:0] + 2'h1;
      end
    end
  end

  // page buffer collects data bytes until the stop
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      page_valid_q <= '0;
      page_base_q <= '0;
      for (int i = 0; i < PAGE_BYTES; i++) begin
        page_buf_q[i] <= 8'h00;
      end
    end else if (prog_done) begin
      page_valid_q <= '0;
    end else if (!busy_q) begin
      if (start_ev || (stop_ev && !prog_start)) begin
        page_valid_q <= '0;
      end else if ((state_q == TWE_WDATA) && byte_done) begin
        page_buf_q[addr_q[PAGE_W-1:0]] <= rx_byte;
        page_valid_q[addr_q[PAGE_W-1:0]] <= 1'b1;
        page_base_q <= addr_q[ADDR_W-1:PAGE_W];
      end
    end
  end

  // self-timed programming cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      busy_q <= 1'b0;
      prog_cnt_q <= '0;
    end else if (busy_q) begin
      if (prog_done) begin
        busy_q <= 1'b0;
      end else begin
        prog_cnt_q <= prog_cnt_q + 1'b1;
      end
    end else if (prog_start) begin
      busy_q <= 1'b1;
      prog_cnt_q <= '0;
    end
  end

  // commit buffered bytes to the array at the end of programming
  always_ff @(posedge sys_clk) begin
    if (prog_done) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (page_valid_q[i]) begin
          mem[{page_base_q, PAGE_W'(i)}] <= page_buf_q[i];
        end
      end
    end
  end

  assign sda_oe = sda_oe_q;
  assign sda_out = sda_out_q;
  assign prog_busy = busy_q;

endmodule // twe_eeprom_slave

`default_nettype wire

// *** tb/twe_eeprom_slave_asserts.sv ***
// concurrent checks on the ports of the two-wire memory slave
`timescale 1ns/1ps
`default_nettype none
module twe_eeprom_slave_asserts
  import twe_pkg::*;
#(
  parameter int unsigned PROG_CYCLES_P = PROG_CYCLES
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [STRAP_W-1:0] slave_select_straps,
  input wire logic write_inhibit_input,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic prog_busy
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  // length of the current programming window
  logic [31:0] busy_cnt_q;
  always_ff @(posedge sys_clk) begin
    if (srst || !prog_busy) begin
      busy_cnt_q <= '0;
    end else begin
      busy_cnt_q <= busy_cnt_q + 32'h0000_0001;
    end
  end

  property p_od;
    sda_oe |-> !sda_out;
  endproperty
  a_od: assert property (p_od) else $error("data driven high");
  property p_oe_rise_low;
    $rose(sda_oe) |-> !scl_in;
  endproperty
  a_oe_rise_low: assert property (p_oe_rise_low)
    else $error("data pulled while clock high");
  property p_high_stable;
    $rose(scl_in) |=> $stable(sda_oe) [*4];
  endproperty
  a_high_stable: assert property (p_high_stable)
    else $error("data moved in clock high phase");
  property p_ack_hold;
    ($rose(sda_oe) && !scl_in) |-> sda_oe [*5];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("pull-down dropped early");
  property p_busy_quiet;
    prog_busy |-> !sda_oe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("answer during programming");
  property p_busy_len;
    $fell(prog_busy) |-> busy_cnt_q == PROG_CYCLES_P;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("programming window length wrong");
  property p_busy_stop;
    $rose(prog_busy) |-> scl_in && sda_in && !$past(sda_in, 6);
  endproperty
  a_busy_stop: assert property (p_busy_stop)
    else $error("programming began without stop");
  property p_busy_inhibit;
    $rose(prog_busy) |-> !$past(write_inhibit_input, 6);
  endproperty
  a_busy_inhibit: assert property (p_busy_inhibit)
    else $error("programming while inhibited");
  property p_rst_quiet;
    $past(srst) |-> !sda_oe && !prog_busy;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("activity right after reset");
endmodule // twe_eeprom_slave_asserts
`default_nettype wire

// *** tb/twe_bus_master.sv ***
// two-wire bus master model: drives clock and open-drain data
`timescale 1ns/1ps
`default_nettype none
module twe_bus_master (
  input wire logic sys_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic start_cond();
    sda_low = 1'b0;
    hold(5);
    scl = 1'b1;
    hold(10);
    sda_low = 1'b1;
    hold(10);
    scl = 1'b0;
    hold(5);
  endtask
  // entered only after the slave has let go of data
  task automatic stop_cond();
    sda_low = 1'b1;
    hold(5);
    scl = 1'b1;
    hold(10);
    sda_low = 1'b0;
    hold(10);
  endtask
  task automatic bit_io(input logic b, output logic s);
    sda_low = ~b;
    hold(5);
    scl = 1'b1;
    hold(5);
    s = sda_line;
    hold(5);
    scl = 1'b0;
    hold(5);
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic recv_byte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~mack, s);
  endtask
endmodule // twe_bus_master
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the two-wire memory slave
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import twe_pkg::*;
  localparam int unsigned PROG_N = 400;
  logic sys_clk;
  logic srst;
  logic scl;
  logic sda_low;
  logic sda_line;
  logic sda_out;
  logic sda_oe;
  logic prog_busy;
  logic wi;
  logic [2:0] straps;
  logic [7:0] exp_mem [128];
  int fail_count;
  int cmp_count;

  assign sda_line = (sda_oe ? sda_out : 1'b1) & ~sda_low;
  twe_eeprom_slave #(.PROG_CYCLES_P(PROG_N)) dut_u (
    .sys_clk(sys_clk), .srst(srst), .scl_in(scl), .sda_in(sda_line),
    .slave_select_straps(straps), .write_inhibit_input(wi),
    .sda_out(sda_out), .sda_oe(sda_oe), .prog_busy(prog_busy));
  twe_bus_master m_u (
    .sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  function automatic logic [7:0] sel(input logic rd);
    return {TYPE_ID, straps, rd};
  endfunction
  task automatic probe(input logic [7:0] sb, input logic [7:0] e);
    logic a;
    m_u.start_cond();
    m_u.send_byte(sb, a);
    chk("address ack", e, 8'(a));
    m_u.stop_cond();
  endtask
  task automatic wr_seq(input logic [7:0] wa, input logic [7:0] d[5],
                        input int n);
    logic a;
    m_u.start_cond();
    m_u.send_byte(sel(1'b0), a);
    chk("write sel ack", 8'h01, 8'(a));
    m_u.send_byte(wa, a);
    chk("word ack", 8'h01, 8'(a));
    for (int i = 0; i < n; i++) begin
      m_u.send_byte(d[i], a);
      chk("data ack", 8'h01, 8'(a));
    end
    m_u.stop_cond();
  endtask
  task automatic wait_prog(input logic poll_busy);
    int n;
    n = 0;
    while (prog_busy !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    chk("busy rise", 8'h01, 8'(prog_busy));
    if (prog_busy !== 1'b1) give_verdict();
    if (poll_busy) probe(sel(1'b0), 8'h00);
    n = 0;
    while (prog_busy !== 1'b0 && n < PROG_N + 20) begin
      @(negedge sys_clk);
      n++;
    end
    chk("busy fall", 8'h00, 8'(prog_busy));
    if (prog_busy !== 1'b0) give_verdict();
  endtask
  task automatic rd_seq(input logic [7:0] wa, input int n, input logic rnd);
    logic a;
    logic [7:0] d;
    m_u.start_cond();
    if (rnd) begin
      m_u.send_byte(sel(1'b0), a);
      m_u.send_byte(wa, a);
      m_u.start_cond();
    end
    m_u.send_byte(sel(1'b1), a);
    chk("read sel ack", 8'h01, 8'(a));
    for (int i = 0; i < n; i++) begin
      m_u.recv_byte(i < n - 1, d);
      chk("read data", exp_mem[7'(wa + i)], d);
    end
    chk("nack release", 8'h00, 8'(sda_oe));
    m_u.stop_cond();
  endtask

  task automatic t_byte_write();
    wr_seq(8'h85, '{8'ha5, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
    exp_mem[5] = 8'ha5;
    wait_prog(1'b1);
    probe(sel(1'b0), 8'h01);
    rd_seq(8'h05, 1, 1'b1);
  endtask
  task automatic t_page_write();
    wr_seq(8'h12, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55}, 5);
    exp_mem[16] = 8'h33;
    exp_mem[17] = 8'h44;
    exp_mem[18] = 8'h55;
    exp_mem[19] = 8'h22;
    wait_prog(1'b0);
    rd_seq(8'h10, 2, 1'b1);
    rd_seq(8'h12, 2, 1'b0);
  endtask
  task automatic t_reject();
    probe({TYPE_ID, ~straps, 1'b0}, 8'h00);
    probe({~TYPE_ID, straps, 1'b0}, 8'h00);
  endtask
  task automatic t_inhibit();
    wi = 1'b1;
    wr_seq(8'h05, '{8'h5a, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
    m_u.hold(30);
    chk("inhibited busy", 8'h00, 8'(prog_busy));
    wi = 1'b0;
    rd_seq(8'h05, 1, 1'b1);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    srst = 1'b1;
    wi = 1'b0;
    straps = 3'h6;
    fail_count = 0;
    cmp_count = 0;
    repeat (5) @(negedge sys_clk);
    srst = 1'b0;
    repeat (5) @(negedge sys_clk);
    t_reject();
    t_byte_write();
    t_page_write();
    t_inhibit();
    give_verdict();
  end
endmodule // testbench

bind twe_eeprom_slave twe_eeprom_slave_asserts #(
  .PROG_CYCLES_P(PROG_CYCLES_P)) chk_u (
  .sys_clk(sys_clk), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
  .slave_select_straps(slave_select_straps),
  .write_inhibit_input(write_inhibit_input), .sda_out(sda_out),
  .sda_oe(sda_oe), .prog_busy(prog_busy));
`default_nettype wire
